// ===== hw/tpg_pkg.sv
/*
  Constants, register map and carrier types for the test pattern generator/detector.
  Assumes the APB slave decodes a word index, byte address = 4 * index.
*/
package tpg_pkg;

  localparam int ADDR_W = 12;

  // Register word indices
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_IRQ  = 8'h61;
  localparam logic [7:0] IDX_LEN  = 8'h62;
  localparam logic [7:0] IDX_TAP  = 8'h63;
  localparam logic [7:0] IDX_ERR  = 8'h64;
  localparam logic [7:0] IDX_INS0 = 8'h68;
  localparam logic [7:0] IDX_INS1 = 8'h69;
  localparam logic [7:0] IDX_INS2 = 8'h6A;
  localparam logic [7:0] IDX_INS3 = 8'h6B;
  localparam logic [7:0] IDX_RES0 = 8'h6C;
  localparam logic [7:0] IDX_RES1 = 8'h6D;
  localparam logic [7:0] IDX_RES2 = 8'h6E;
  localparam logic [7:0] IDX_RES3 = 8'h6F;
  localparam logic [7:0] IDX_PERFORMANCE_MONITOR = 8'h7F;

  // Interrupt enable/status field positions
  localparam int IRQ_OVR   = 0;
  localparam int IRQ_XFER  = 1;
  localparam int IRQ_BE    = 2;
  localparam int IRQ_SYNC_CHANGE_FLAG = 3;
  localparam int IRQ_SYNC_STATE = 4;
  localparam int IRQ_UPDATE_IRQ_ENABLE = 5;
  localparam int IRQ_BEE   = 6;
  localparam int IRQ_SYNC_CHANGE_IRQ_ENABLE = 7;

  // Error insertion fields
  localparam int ERR_EVENT = 3;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h02;

  // Result function codes
  localparam logic [1:0] RSEL_ERRORS = 2'h2;
  localparam logic [1:0] RSEL_BITS   = 2'h3;

  // Synchronisation figures, in received bits
  localparam logic [5:0] SYNC_GOOD_BITS   = 6'h30;
  localparam logic [5:0] LOSS_WINDOW_BITS = 6'h30;
  localparam logic [3:0] LOSS_ERR_LIMIT   = 4'hA;

  // Refresh period
  localparam int CLK_HZ            = 40_000_000;
  localparam int REFRESH_PERIOD_S  = 1;
  localparam int REFRESH_CYCLES    = REFRESH_PERIOD_S * CLK_HZ;

  // Bits between injected errors, by rate code (0 and 1 = none)
  localparam logic [7:0][23:0] RATE_PERIOD = {
    24'h989680, 24'h0F4240, 24'h0186A0, 24'h002710,
    24'h0003E8, 24'h000064, 24'h000000, 24'h000000};

  typedef enum logic [1:0] {
    TPG_SEARCH = 2'b00,
    TPG_LOCKED = 2'b01,
    TPG_HALTED = 2'b10
  } tpg_sync_t;

  typedef struct packed {
    logic [1:0] resultSel;
    logic       reserved;
    logic       patType;
    logic       txInv;
    logic       rxInv;
    logic       auto_resync_enable;
    logic       manual_resync;
  } tpg_ctrl_t;

  typedef struct packed {
    logic [4:0]  len;
    logic [4:0]  tap;
    logic [31:0] insert;
  } tpg_cfg_t;

endpackage : tpg_pkg

// ===== hw/tpg_gen_detect.sv
/*
  Test pattern generator and detector with APB register access.
  Assumes bit strobes and receive data come from framer logic on clk_sys.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps

// Function
// R1 - Rising edge on manual resync bit restarts the sync search
// R2 - Software should resync after any configuration or source change
// R3 - Interrupt output driven only for flags whose enable is set
// R4 - Ten or more errors in a 48-bit window drops sync
// R5 - 48 consecutive error-free bits declare sync
// R6 - Sync change flag sets on any sync change, clears on read
// R7 - Bit error flag sets on detected errors, clears on read; the code sets it only on errors detected while in sync
// R8 - Update flag sets on each result refresh, clears on read
// R9 - Overwrite flag sets when unread results are overwritten, clears on read
// R10 - Pattern length is length field plus one
// R11 - Feedback tap is tap field plus one; software keeps it below length
// R12 - Each rise of the event bit injects exactly one error
// R13 - Rate code picks injected error rate; 000 and 001 inject none
// R14 - Software writes zero code before changing between nonzero rates
// R15 - Repetitive mode sends insertion value from bit 31 downward, repeating
// R16 - Insertion value seeds the pseudo-random generator; software loads ones
// R17 - Writing the top insertion byte commits the configuration
// R18 - Result select 00 or 01 shows the received pattern
// R19 - Select 10 shows error count; no counting while out of sync
// R20 - Select 11 shows total received bit count
// R21 - Results refresh each second and on result or monitor writes
// R22 - Pattern type bit picks pseudo-random or repetitive for both ends
// R23 - Transmit invert bit inverts the generated pattern
// R24 - Receive invert bit inverts incoming data before checking
// R25 - Auto resync restarts search after loss; enabled after reset
// R26 - Detector compares each bit with a locally regenerated expected bit
module tpg_gen_detect #(
  parameter int REFRESH_CYCLES = tpg_pkg::REFRESH_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic [tpg_pkg::ADDR_W-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      txBitEn,
  output logic                           txBitData,
  input  wire logic                      rxBitEn,
  input  wire logic                      rxBitData,
  output logic                           irqB
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  tpg_pkg::tpg_ctrl_t ctrl_reg;
  tpg_pkg::tpg_cfg_t  cfg_reg;
  tpg_pkg::tpg_sync_t state_reg;
  logic [4:0]  lenShadow_reg;
  logic [4:0]  tapShadow_reg;
  logic [3:0]  err_reg;
  logic [23:0] insShadow_reg;
  logic [2:0]  irqEn_reg;
  logic        syncChange_reg;
  logic        bitError_reg;
  logic        update_reg;
  logic        overwrite_reg;
  logic        syncPrev_reg;
  logic        manPrev_reg;
  logic        evtPrev_reg;
  logic        evtPending_reg;
  logic [31:0] prbs_reg;
  logic [4:0]  txPtr_reg;
  logic [23:0] rateCnt_reg;
  logic [31:0] hist_reg;
  logic [5:0]  goodCnt_reg;
  logic [5:0]  winCnt_reg;
  logic [3:0]  winErr_reg;
  logic [31:0] bitCount_reg;
  logic [31:0] errCount_reg;
  logic [31:0] result_reg;
  logic [31:0] secCnt_reg;
  logic        preadyReg;
  logic        pslverrReg;
  logic [31:0] prdataReg;
  logic        txBitReg;
  logic        irqBReg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire logic [7:0] regIdx     = paddr[9:2];
  wire logic       setupDone  = psel & penable & ~preadyReg;
  wire logic       accessDone = psel & penable & preadyReg;
  wire logic       idxMapped  = (regIdx >= tpg_pkg::IDX_CTRL && regIdx <= tpg_pkg::IDX_ERR)
                              || (regIdx >= tpg_pkg::IDX_INS0 && regIdx <= tpg_pkg::IDX_RES3)
                              || (regIdx == tpg_pkg::IDX_PERFORMANCE_MONITOR);
  wire logic       addrOk     = idxMapped && (paddr[1:0] == 2'h0)
                              && (paddr[tpg_pkg::ADDR_W-1:10] == '0);
  wire logic       writeEn    = accessDone & pwrite & addrOk;
  wire logic [7:0] wb         = pwdata[7:0];
  wire logic       wrCtrl     = writeEn && regIdx == tpg_pkg::IDX_CTRL;
  wire logic       wrIrq      = writeEn && regIdx == tpg_pkg::IDX_IRQ;
  wire logic       wrLen      = writeEn && regIdx == tpg_pkg::IDX_LEN;
  wire logic       wrTap      = writeEn && regIdx == tpg_pkg::IDX_TAP;
  wire logic       wrErr      = writeEn && regIdx == tpg_pkg::IDX_ERR;
  wire logic       wrIns0     = writeEn && regIdx == tpg_pkg::IDX_INS0;
  wire logic       wrIns1     = writeEn && regIdx == tpg_pkg::IDX_INS1;
  wire logic       wrIns2     = writeEn && regIdx == tpg_pkg::IDX_INS2;
  wire logic       wrIns3     = writeEn && regIdx == tpg_pkg::IDX_INS3;
  wire logic       wrRes      = writeEn && ((regIdx >= tpg_pkg::IDX_RES0
                              && regIdx <= tpg_pkg::IDX_RES3) || regIdx == tpg_pkg::IDX_PERFORMANCE_MONITOR);
  wire logic       irqRead    = accessDone & ~pwrite & addrOk && regIdx == tpg_pkg::IDX_IRQ;
  // Only bits reported to software are cleared; later events survive
  wire logic [7:0] clrMask    = irqRead ? prdataReg[7:0] : 8'h00;

  wire logic [7:0] irqView = {irqEn_reg, syncPrev_reg, syncChange_reg,
                              bitError_reg, update_reg, overwrite_reg};
  logic [7:0] readMux;

  always_comb
  begin
    case (regIdx)
      tpg_pkg::IDX_CTRL: readMux = ctrl_reg;
      tpg_pkg::IDX_IRQ:  readMux = irqView;
      tpg_pkg::IDX_LEN:  readMux = {3'h0, lenShadow_reg};
      tpg_pkg::IDX_TAP:  readMux = {3'h0, tapShadow_reg};
      tpg_pkg::IDX_ERR:  readMux = {4'h0, err_reg};
      tpg_pkg::IDX_INS0: readMux = insShadow_reg[7:0];
      tpg_pkg::IDX_INS1: readMux = insShadow_reg[15:8];
      tpg_pkg::IDX_INS2: readMux = insShadow_reg[23:16];
      tpg_pkg::IDX_INS3: readMux = cfg_reg.insert[31:24];
      tpg_pkg::IDX_RES0: readMux = result_reg[7:0];
      tpg_pkg::IDX_RES1: readMux = result_reg[15:8];
      tpg_pkg::IDX_RES2: readMux = result_reg[23:16];
      tpg_pkg::IDX_RES3: readMux = result_reg[31:24];
      default:           readMux = 8'h00;
    endcase
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= 32'h00000000;
    end
    else
    begin
      preadyReg  <= setupDone;
      pslverrReg <= setupDone & ~addrOk;
      if (setupDone)
        prdataReg <= (addrOk && !pwrite) ? {24'h000000, readMux} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_reg      <= tpg_pkg::CTRL_RESET;
      irqEn_reg     <= 3'h0;
      lenShadow_reg <= 5'h00;
      tapShadow_reg <= 5'h00;
      err_reg       <= 4'h0;
      insShadow_reg <= 24'h000000;
      cfg_reg       <= '0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= wb & 8'hDF;
      if (wrIrq)
        irqEn_reg <= wb[tpg_pkg::IRQ_SYNC_CHANGE_IRQ_ENABLE:tpg_pkg::IRQ_UPDATE_IRQ_ENABLE];
      if (wrLen)
        lenShadow_reg <= wb[4:0];
      if (wrTap)
        tapShadow_reg <= wb[4:0];
      if (wrErr)
        err_reg <= wb[3:0];
      if (wrIns0)
        insShadow_reg[7:0] <= wb;
      if (wrIns1)
        insShadow_reg[15:8] <= wb;
      if (wrIns2)
        insShadow_reg[23:16] <= wb;
      // R17 top byte commits
      if (wrIns3)
        cfg_reg <= {lenShadow_reg, tapShadow_reg, wb, insShadow_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator

  wire logic       manRise   = ctrl_reg.manual_resync & ~manPrev_reg;
  wire logic       evtRise   = err_reg[tpg_pkg::ERR_EVENT] & ~evtPrev_reg;
  wire logic [2:0] rateCode  = err_reg[2:0];
  wire logic [23:0] period   = tpg_pkg::RATE_PERIOD[rateCode];
  // R13 rate counter hit
  wire logic       rateHit   = (period != 24'h000000) && (rateCnt_reg == period - 24'h000001);
  // R11 feedback from length and tap stages
  wire logic       prbsBit   = prbs_reg[cfg_reg.len] ^ prbs_reg[cfg_reg.tap];
  // R15 repetitive window ends at bit 31 - len
  wire logic [4:0] ptrLast   = 5'h1F - cfg_reg.len;
  // R22 pattern type select
  wire logic       genBit    = ctrl_reg.patType ? cfg_reg.insert[txPtr_reg] : prbsBit;
  wire logic       injectErr = evtPending_reg | rateHit;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      manPrev_reg    <= 1'b0;
      evtPrev_reg    <= 1'b0;
      evtPending_reg <= 1'b0;
      prbs_reg       <= 32'h00000000;
      txPtr_reg      <= 5'h1F;
      rateCnt_reg    <= 24'h000000;
      txBitReg       <= 1'b0;
    end
    else
    begin
      manPrev_reg <= ctrl_reg.manual_resync;
      evtPrev_reg <= err_reg[tpg_pkg::ERR_EVENT];
      // R12 one error per event rise
      if (evtRise)
        evtPending_reg <= 1'b1;
      else if (txBitEn)
        evtPending_reg <= 1'b0;
      // R16 insertion value seeds generator
      if (wrIns3)
      begin
        prbs_reg  <= {wb, insShadow_reg};
        txPtr_reg <= 5'h1F;
      end
      else if (txBitEn)
      begin
        prbs_reg  <= {prbs_reg[30:0], prbsBit};
        txPtr_reg <= (txPtr_reg == ptrLast) ? 5'h1F : txPtr_reg - 5'h01;
      end
      if (wrErr || period == 24'h000000)
        rateCnt_reg <= 24'h000000;
      else if (txBitEn)
        rateCnt_reg <= rateHit ? 24'h000000 : rateCnt_reg + 24'h000001;
      // R23 transmit inversion
      if (txBitEn)
        txBitReg <= genBit ^ ctrl_reg.txInv ^ injectErr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector

  // R24 receive inversion
  wire logic       rxBit    = rxBitData ^ ctrl_reg.rxInv;
  // R26 expected bit regenerated from received history
  wire logic       expBit   = ctrl_reg.patType ? hist_reg[cfg_reg.len]
                            : hist_reg[cfg_reg.len] ^ hist_reg[cfg_reg.tap];
  wire logic       bitErr   = rxBitEn && (rxBit != expBit);
  wire logic       locked   = state_reg == tpg_pkg::TPG_LOCKED;
  wire logic [3:0] winErrs  = winErr_reg + {3'h0, bitErr};
  wire logic       lossNow  = locked && rxBitEn && winErrs >= tpg_pkg::LOSS_ERR_LIMIT;
  wire logic       goodLast = goodCnt_reg == tpg_pkg::SYNC_GOOD_BITS - 6'h01;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg   <= tpg_pkg::TPG_SEARCH;
      hist_reg    <= 32'h00000000;
      goodCnt_reg <= 6'h00;
      winCnt_reg  <= 6'h00;
      winErr_reg  <= 4'h0;
    end
    else
    begin
      if (rxBitEn)
        hist_reg <= {hist_reg[30:0], rxBit};
      // R1 manual resync restarts search
      if (manRise)
      begin
        state_reg   <= tpg_pkg::TPG_SEARCH;
        goodCnt_reg <= 6'h00;
      end
      else
      begin
        case (state_reg)
          tpg_pkg::TPG_SEARCH:
            if (rxBitEn)
            begin
              goodCnt_reg <= bitErr ? 6'h00 : goodCnt_reg + 6'h01;
              // R5 error-free run declares sync
              if (!bitErr && goodLast)
              begin
                state_reg  <= tpg_pkg::TPG_LOCKED;
                winCnt_reg <= 6'h00;
                winErr_reg <= 4'h0;
              end
            end
          tpg_pkg::TPG_LOCKED:
            if (lossNow)
            begin
              // R4 R25 loss, then optional auto search
              state_reg   <= ctrl_reg.auto_resync_enable ? tpg_pkg::TPG_SEARCH : tpg_pkg::TPG_HALTED;
              goodCnt_reg <= 6'h00;
            end
            else if (rxBitEn)
            begin
              if (winCnt_reg == tpg_pkg::LOSS_WINDOW_BITS - 6'h01)
              begin
                winCnt_reg <= 6'h00;
                winErr_reg <= 4'h0;
              end
              else
              begin
                winCnt_reg <= winCnt_reg + 6'h01;
                winErr_reg <= winErrs;
              end
            end
          tpg_pkg::TPG_HALTED:
            state_reg <= tpg_pkg::TPG_HALTED;
          default:
            state_reg <= tpg_pkg::TPG_SEARCH;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters, results and status

  wire logic        secHit   = secCnt_reg == REFRESH_CYCLES - 1;
  // R21 timed or written refresh
  wire logic        refresh  = secHit | wrRes;
  wire logic        errInc   = bitErr & locked;
  wire logic [31:0] bitNext  = refresh ? 32'h00000000 : bitCount_reg + {31'h0, rxBitEn};
  wire logic [31:0] errNext  = refresh ? 32'h00000000 : errCount_reg + {31'h0, errInc};
  wire logic [2:0]  irqTerms = irqEn_reg & {syncChange_reg, bitError_reg, update_reg};
  logic [31:0] resultSel;

  // R18 R19 R20 result function
  always_comb
  begin
    case (ctrl_reg.resultSel)
      tpg_pkg::RSEL_ERRORS: resultSel = errCount_reg;
      tpg_pkg::RSEL_BITS:   resultSel = bitCount_reg;
      default:              resultSel = hist_reg;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      secCnt_reg     <= 32'h00000000;
      bitCount_reg   <= 32'h00000000;
      errCount_reg   <= 32'h00000000;
      result_reg     <= 32'h00000000;
      syncPrev_reg   <= 1'b0;
      syncChange_reg <= 1'b0;
      bitError_reg   <= 1'b0;
      update_reg     <= 1'b0;
      overwrite_reg  <= 1'b0;
      irqBReg        <= 1'b1;
    end
    else
    begin
      secCnt_reg <= secHit ? 32'h00000000 : secCnt_reg + 32'h00000001;
      // R19 errors only counted in sync
      errCount_reg <= errNext;
      bitCount_reg <= bitNext;
      if (refresh)
        result_reg <= resultSel;
      syncPrev_reg <= locked;
      // R6 set on either sync change
      syncChange_reg <= (locked != syncPrev_reg) | (syncChange_reg & ~clrMask[tpg_pkg::IRQ_SYNC_CHANGE_FLAG]);
      // R7 set on errors detected while in sync
      bitError_reg <= errInc | (bitError_reg & ~clrMask[tpg_pkg::IRQ_BE]);
      // R8 set on refresh
      update_reg <= refresh | (update_reg & ~clrMask[tpg_pkg::IRQ_XFER]);
      // R9 unread results overwritten
      overwrite_reg <= (refresh & update_reg) | (overwrite_reg & ~clrMask[tpg_pkg::IRQ_OVR]);
      // R3 enabled flags only
      irqBReg <= ~(|irqTerms);
    end
  end

  assign prdata    = prdataReg;
  assign pready    = preadyReg;
  assign pslverr   = pslverrReg;
  assign txBitData = txBitReg;
  assign irqB      = irqBReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  resync_search_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
    manRise |=> state_reg == tpg_pkg::TPG_SEARCH)
    else $error("manual resync did not restart search");

  sync_declare_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    (state_reg == tpg_pkg::TPG_SEARCH && rxBitEn && !bitErr && goodLast && !manRise)
    |=> locked)
    else $error("sync not declared after error-free run");

  sync_loss_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    (lossNow && !manRise) |=> !locked ##1 syncChange_reg)
    else $error("sync not dropped after error limit");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
    (irqEn_reg == 3'h0) [*2] |-> irqB)
    else $error("interrupt asserted with all enables off");

  sync_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    (locked != $past(locked)) |=> syncChange_reg)
    else $error("sync change flag missed");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    (irqRead && prdataReg[tpg_pkg::IRQ_BE] && !errInc) |=> !bitError_reg)
    else $error("bit error flag not cleared by read");

  count_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    (!locked && !refresh) |=> errCount_reg == $past(errCount_reg))
    else $error("errors counted out of sync");

  refresh_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    (refresh && update_reg) |=> update_reg && overwrite_reg)
    else $error("refresh flags wrong");

  apb_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    setupDone |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

endmodule : tpg_gen_detect

// ===== bench/tpg_framer_model.sv
/*
  Framer bit-path model: transmit bit strobes and a loopback receive path.
  Assumes the pattern block runs on the same clk_sys and resets with rst_b.
*/
`timescale 1ns/1ps

module tpg_framer_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic txBitData,
  input  wire logic flipBit,
  output logic      txBitEn,
  output logic      rxBitEn,
  output logic      rxBitData
);
  logic [1:0] phaseReg;
  logic       idleReg;

  ////////////////////////////////////////////////////////////////////////////
  // One bit every four cycles, looped back the cycle after it is sent
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      phaseReg <= 2'h0;
      txBitEn  <= 1'h0;
      rxBitEn  <= 1'h0;
      idleReg  <= 1'h0;
    end
    else
    begin
      phaseReg <= phaseReg + 2'h1;
      txBitEn  <= (phaseReg == 2'h3);
      rxBitEn  <= txBitEn;
      idleReg  <= ~idleReg;
    end
  end

  // Toggles off-strobe, so no stale bit can pass for a valid one
  assign rxBitData = rxBitEn ? (txBitData ^ flipBit) : idleReg;
endmodule : tpg_framer_model

// ===== bench/tb_tpg_gen_detect.sv
/*
  Self-checking bench for the pattern generator/detector over APB.
  Assumes the framer loopback model on the bit side and one 40 MHz clock.
*/
`timescale 1ns/1ps

module tb_tpg_gen_detect;
  localparam logic [31:0] PAT = 32'hA5C30F96;
  logic                        clk_sys;
  logic                        rst_b;
  logic [tpg_pkg::ADDR_W-1:0]  paddr;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [31:0]                 pwdata;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        txBitEn;
  logic                        txBitData;
  logic                        rxBitEn;
  logic                        rxBitData;
  logic                        irqB;
  logic                        flipBit;
  logic [31:0]                 rdData;
  logic                        rdErr;
  logic [31:0]                 resWord;
  logic                        txQ[$];
  int                          numErrors;
  int                          comparisons;
  int                          cycles;

  // Short refresh period keeps the periodic case inside the run
  tpg_gen_detect #(.REFRESH_CYCLES(20000)) u_tpg_gen_detect (.clk_sys, .rst_b, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .txBitEn,
    .txBitData, .rxBitEn, .rxBitData, .irqB);
  tpg_framer_model u_tpg_framer_model (.clk_sys, .rst_b, .txBitData, .flipBit,
    .txBitEn, .rxBitEn, .rxBitData);

  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Low phase: strobes and bits launched at the last edge have settled
  always @(negedge clk_sys)
  begin
    if (rxBitEn === 1'h1)
      txQ.push_back(txBitData);
    cycles++;
    if (cycles == 40000)
    begin
      numErrors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
    comparisons++;
    if (got !== expv)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, expv, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    paddr   <= {2'h0, idx, 2'h0};
    pwrite  <= wr;
    pwdata  <= {24'h0, wd};
    psel    <= 1'h1;
    penable <= 1'h0;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    check("pready", 32'h1, {31'h0, pready});
    rdData = prdata;
    rdErr  = pslverr;
    // Request held through the edge that samples pready high
    @(posedge clk_sys);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] expv,
                     input logic [7:0] mask);
    apb(1'h0, idx, 8'h00);
    check(name, {24'h0, expv & mask}, rdData & {24'h0, mask});
  endtask : rdc

  task automatic irqchk(input string name, input logic expv);
    @(negedge clk_sys);
    check(name, {31'h0, expv}, {31'h0, irqB});
    @(posedge clk_sys);
  endtask : irqchk

  task automatic bits(input int n);
    repeat (n * 4) @(posedge clk_sys);
  endtask : bits

  task automatic rdres;
    int k;
    for (k = 0; k < 4; k++)
    begin
      apb(1'h0, tpg_pkg::IDX_RES0 + 8'(k), 8'h00);
      resWord[8*k +: 8] = rdData[7:0];
    end
  endtask : rdres

  // One 32-bit window starting in the first 32 captured bits must match the expected word
  task automatic findpat(input string name, input logic [31:0] expv);
    int          k;
    int          i;
    logic [31:0] w;
    logic        hit;
    hit = 1'h0;
    w   = 32'h0;
    for (k = 0; k < 32; k++)
    begin
      for (i = 0; i < 32; i++)
        w = {w[30:0], txQ[k + i]};
      if (w === expv)
        hit = 1'h1;
    end
    check(name, 32'h1, {31'h0, hit});
  endtask : findpat

  task finish_test;
    $display("Comparisons %0d errors %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b   = 1'h0;
    paddr   = '0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    pwdata  = 32'h0;
    flipBit = 1'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    irqchk("irqIdle", 1'h1);
    rdc("ctrlReset", tpg_pkg::IDX_CTRL, 8'h02, 8'hFF);
    rdc("irqEnReset", tpg_pkg::IDX_IRQ, 8'h00, 8'hE0);
    for (int k = 8'h62; k <= 8'h6B; k++)
    begin
      rdc("cfgReset", 8'(k), 8'h00, 8'hFF);
      check("slvErr", {31'h0, k >= 8'h65 && k <= 8'h67}, {31'h0, rdErr});
    end
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h12);
    apb(1'h1, tpg_pkg::IDX_LEN, 8'h1F);
    apb(1'h1, tpg_pkg::IDX_TAP, 8'h00);
    apb(1'h1, tpg_pkg::IDX_INS0, 8'h96);
    apb(1'h1, tpg_pkg::IDX_INS1, 8'h0F);
    apb(1'h1, tpg_pkg::IDX_INS2, 8'hC3);
    txQ.delete();
    bits(70);
    findpat("uncommitted", 32'h0);
    apb(1'h1, tpg_pkg::IDX_INS3, 8'hA5);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h13);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h12);
    txQ.delete();
    bits(70);
    findpat("repetitive", PAT);
    bits(30);
    rdc("syncGained", tpg_pkg::IDX_IRQ, 8'h18, 8'h18);
    rdc("syncChgClear", tpg_pkg::IDX_IRQ, 8'h10, 8'h18);
    apb(1'h1, tpg_pkg::IDX_IRQ, 8'h80);
    irqchk("irqMasked", 1'h1);
    // 24 errors in a row: any 48-bit window split still holds ten
    flipBit <= 1'h1;
    bits(24);
    flipBit <= 1'h0;
    irqchk("irqSync", 1'h0);
    rdc("syncLost", tpg_pkg::IDX_IRQ, 8'h0C, 8'h1C);
    irqchk("irqCleared", 1'h1);
    bits(120);
    rdc("autoRelock", tpg_pkg::IDX_IRQ, 8'h18, 8'h18);
    apb(1'h1, tpg_pkg::IDX_IRQ, 8'h00);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h1E);
    txQ.delete();
    bits(70);
    findpat("txInverted", ~PAT);
    rdc("rxInvKeepsSync", tpg_pkg::IDX_IRQ, 8'h10, 8'h18);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h92);
    // Let an inversion-switch glitch and its echo pass before counting
    bits(40);
    apb(1'h0, tpg_pkg::IDX_IRQ, 8'h00);
    apb(1'h1, tpg_pkg::IDX_RES0, 8'h00);
    apb(1'h1, tpg_pkg::IDX_ERR, 8'h08);
    bits(50);
    apb(1'h1, tpg_pkg::IDX_RES0, 8'h00);
    rdc("updOvr", tpg_pkg::IDX_IRQ, 8'h03, 8'h03);
    rdc("ovrClear", tpg_pkg::IDX_IRQ, 8'h00, 8'h03);
    rdres();
    check("eventErrors", 32'h2, resWord);
    apb(1'h1, tpg_pkg::IDX_ERR, 8'h01);
    apb(1'h1, tpg_pkg::IDX_PERFORMANCE_MONITOR, 8'h00);
    bits(150);
    apb(1'h1, tpg_pkg::IDX_PERFORMANCE_MONITOR, 8'h00);
    rdres();
    check("rateNone", 32'h0, resWord);
    apb(1'h1, tpg_pkg::IDX_ERR, 8'h00);
    apb(1'h1, tpg_pkg::IDX_ERR, 8'h02);
    apb(1'h1, tpg_pkg::IDX_RES3, 8'h00);
    bits(250);
    apb(1'h1, tpg_pkg::IDX_RES3, 8'h00);
    rdres();
    check("ratePercent", 32'h1, {31'h0, resWord >= 2 && resWord <= 6});
    apb(1'h1, tpg_pkg::IDX_ERR, 8'h00);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'hD2);
    apb(1'h1, tpg_pkg::IDX_RES1, 8'h00);
    bits(100);
    apb(1'h1, tpg_pkg::IDX_RES1, 8'h00);
    rdres();
    check("bitCount", 32'h1, {31'h0, resWord >= 99 && resWord <= 102});
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h02);
    apb(1'h1, tpg_pkg::IDX_LEN, 8'h06);
    apb(1'h1, tpg_pkg::IDX_TAP, 8'h05);
    for (int k = 0; k < 4; k++)
      apb(1'h1, tpg_pkg::IDX_INS0 + 8'(k), 8'hFF);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h03);
    apb(1'h1, tpg_pkg::IDX_CTRL, 8'h02);
    bits(110);
    rdc("prbsSync", tpg_pkg::IDX_IRQ, 8'h10, 8'h10);
    apb(1'h0, tpg_pkg::IDX_IRQ, 8'h00);
    rdc("noUpdate", tpg_pkg::IDX_IRQ, 8'h00, 8'h02);
    repeat (20100) @(posedge clk_sys);
    rdc("periodicUpd", tpg_pkg::IDX_IRQ, 8'h02, 8'h02);
    finish_test();
  end
endmodule : tb_tpg_gen_detect
